// ===== hw/ccg_control.sv
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
// What this block does
// - Flip carry: H gets old C, N cleared
// - Opcode 3F flips carry in one cycle
// - Opcode 37 forces carry in one cycle
// - Force carry clears H and N only
// - Opcode 76 suspends until interrupt or reset
// - Suspended core keeps running idle cycles
// - Opcode F3 clears both latches at once
// - Masked requests ignored until re-enabled
// - Opcode FB sets both enable latches
// - No acceptance until next instruction completes
// - ED 46 selects scheme zero, two cycles
// - Scheme zero executes byte from acknowledge
// - Further jammed bytes use memory reads
// - ED 56 selects restart to 0038
// - ED 5E selects vectored scheme two
// - Pointer is page high, vector low
// - Table entry becomes service routine address
module ccg_control
  import ccg_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        sys_rst_in,
  input  wire logic [7:0]  data_in,
  input  wire logic        irq_req_in,
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output ccg_cyc_t         cyc_out,
  output logic      [7:0]  reg_rdata_out,
  output logic             halt_out,
  output logic             latch_a_out,
  output logic             latch_b_out,
  output ccg_scheme_t      scheme_out,
  output logic             branch_out,
  output logic      [15:0] branch_addr_out,
  output logic      [7:0]  flags_out
);
  // ==========================================================
  // Opcode classifier
  // ==========================================================
  function automatic ccg_opc_t ccg_classify(input logic [7:0] b);
    case (b)
      OP_FLIP_CY:  ccg_classify = OC_FLIP;
      OP_FORCE_CY: ccg_classify = OC_FORCE;
      OP_HALT:     ccg_classify = OC_HALT;
      OP_MASK:     ccg_classify = OC_MASK;
      OP_UNMASK:   ccg_classify = OC_UNMASK;
      OP_EXT:      ccg_classify = OC_EXT;
      default:     ccg_classify = OC_IDLE;
    endcase
  endfunction : ccg_classify

  // ==========================================================
  // State
  // ==========================================================
  ccg_state_t   state_reg;      // Sequencer state
  ccg_state_t   state_next;     // Its next value
  logic [1:0]   t_reg;          // Clock state in machine cycle
  logic [7:0]   data_reg;       // Byte sampled at third state
  logic [15:0]  pc_reg;         // Fetch address
  logic [15:0]  pc_next;        // Its next value
  logic [15:0]  ptr_reg;        // Table pointer
  logic [7:0]   lo_reg;         // Table entry low byte
  logic [7:0]   page_reg;       // Interrupt page register
  logic         jam_reg;        // Extension byte is jammed
  ccg_cyc_t     cyc_next;       // Next bus cycle
  ccg_opc_t     cls;            // Class of sampled byte
  logic         last;           // Final clock state
  logic         exe;            // Opcode executes now
  logic         ext_done;       // Extension byte executes now
  logic         done_instr;     // Instruction ends now
  logic         take;           // Interrupt accepted now
  logic         br;             // Branch taken now
  logic [15:0]  br_addr;        // Branch target

  // ==========================================================
  // Decode
  // ==========================================================
  // Jammed byte in scheme zero decodes like a fetched one
  always_comb begin
    cls        = ccg_classify(data_reg);
    last       = (t_reg == T_LAST);
    exe        = last && (state_reg == ST_FETCH ||
                 (state_reg == ST_ACK && scheme_out == SCH_JAM));
    ext_done   = last && state_reg == ST_EXT;
    done_instr = (exe && cls != OC_EXT) || ext_done ||
                 (last && state_reg == ST_HALT);
    // Latch gates requests; mask and unmask block their own end
    take       = done_instr && irq_req_in && latch_a_out &&
                 !(exe && (cls == OC_MASK || cls == OC_UNMASK));
  end

  // Next state, branch and fetch address
  always_comb begin
    state_next = state_reg;
    br         = 1'b0;
    br_addr    = pc_reg;
    if (exe) begin
      // Prefix waits for second byte; halt parks
      if (cls == OC_EXT)
        state_next = ST_EXT;
      else if (take)
        state_next = ST_ACK;
      else if (cls == OC_HALT)
        state_next = ST_HALT;
      else
        state_next = ST_FETCH;
    end else if (last) begin
      case (state_reg)
        ST_EXT:    state_next = take ? ST_ACK : ST_FETCH;
        // Idle cycles repeat until a request is taken
        ST_HALT:   state_next = take ? ST_ACK : ST_HALT;
        ST_ACK: begin
          if (scheme_out == SCH_RESTART) begin
            state_next = ST_FETCH;
            br         = 1'b1;
            br_addr    = RESTART_ADDR;
          end else begin
            state_next = ST_TBL_LO;
          end
        end
        ST_TBL_LO: state_next = ST_TBL_HI;
        ST_TBL_HI: begin
          state_next = ST_FETCH;
          br         = 1'b1;
          br_addr    = {data_reg, lo_reg};
        end
        default:   state_next = ST_FETCH;
      endcase
    end
    // Ordinary fetches advance the address
    if (br)
      pc_next = br_addr;
    else if (last && (state_reg == ST_FETCH || (state_reg == ST_EXT && !jam_reg)))
      pc_next = pc_reg + 16'h0001;
    else
      pc_next = pc_reg;
  end

  // Bus cycle for the machine cycle that follows
  always_comb begin
    cyc_next       = '0;
    cyc_next.addr  = pc_next;
    case (state_next)
      ST_FETCH:  cyc_next.fetch = 1'b1;
      ST_EXT: begin
        // Jammed extension bytes come by memory read
        cyc_next.fetch = !(state_reg == ST_ACK);
        cyc_next.mread = (state_reg == ST_ACK);
      end
      ST_ACK:    cyc_next.ack = 1'b1;
      ST_TBL_LO: begin
        cyc_next.mread = 1'b1;
        cyc_next.addr  = {page_reg, data_reg};
      end
      ST_TBL_HI: begin
        cyc_next.mread = 1'b1;
        cyc_next.addr  = ptr_reg + 16'h0001;
      end
      default:   cyc_next.addr = pc_next;
    endcase
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  // Clock states run on every edge, halted or not
  always_ff @(posedge clock_in) begin
    if (sys_rst_in)
      t_reg <= 2'h0;
    else
      t_reg <= t_reg + 2'h1;
  end

  // Sample the data bus
  always_ff @(posedge clock_in) begin
    if (sys_rst_in)
      data_reg <= 8'h00;
    else if (t_reg == T_SAMPLE)
      data_reg <= data_in;
  end

  // State, address and bus cycle at end of each machine cycle
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_FETCH;
      pc_reg    <= PC_RST;
      jam_reg   <= 1'b0;
      ptr_reg   <= 16'h0000;
      lo_reg    <= 8'h00;
      cyc_out   <= '{fetch: 1'b1, ack: 1'b0, mread: 1'b0, addr: PC_RST};
      halt_out  <= 1'b0;
    end else if (last) begin
      state_reg <= state_next;
      pc_reg    <= pc_next;
      jam_reg   <= (state_reg == ST_ACK);
      cyc_out   <= cyc_next;
      halt_out  <= (state_next == ST_HALT);
      if (state_reg == ST_ACK)
        ptr_reg <= {page_reg, data_reg};
      if (state_reg == ST_TBL_LO)
        lo_reg  <= data_reg;
    end
  end

  // Branch pulse
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      branch_out      <= 1'b0;
      branch_addr_out <= 16'h0000;
    end else begin
      branch_out      <= br;
      if (br)
        branch_addr_out <= br_addr;
    end
  end

  // ==========================================================
  // Flags, latches and scheme
  // ==========================================================
  // Flag ops touch only C, H and N; instruction beats bus write
  always_ff @(posedge clock_in) begin
    if (sys_rst_in)
      flags_out <= FLAGS_RST;
    else if (exe && cls == OC_FLIP) begin
      flags_out[F_H] <= flags_out[F_C];
      flags_out[F_N] <= 1'b0;
      flags_out[F_C] <= !flags_out[F_C];
    end else if (exe && cls == OC_FORCE) begin
      flags_out[F_H] <= 1'b0;
      flags_out[F_N] <= 1'b0;
      flags_out[F_C] <= 1'b1;
    end else if (reg_wr_in && reg_addr_in == REG_FLAGS)
      flags_out <= reg_wdata_in;
  end

  // Enable latches; acceptance also clears them
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      latch_a_out <= 1'b0;
      latch_b_out <= 1'b0;
    end else if (take || (exe && cls == OC_MASK)) begin
      latch_a_out <= 1'b0;
      latch_b_out <= 1'b0;
    end else if (exe && cls == OC_UNMASK) begin
      latch_a_out <= 1'b1;
      latch_b_out <= 1'b1;
    end
  end

  // Scheme select from extension byte
  always_ff @(posedge clock_in) begin
    if (sys_rst_in)
      scheme_out <= SCH_JAM;
    else if (ext_done) begin
      case (data_reg)
        OP_SCHEME0: scheme_out <= SCH_JAM;
        OP_SCHEME1: scheme_out <= SCH_RESTART;
        OP_SCHEME2: scheme_out <= SCH_VECTOR;
        default:    scheme_out <= scheme_out;
      endcase
    end
  end

  // ==========================================================
  // Register port
  // ==========================================================
  // Page register write
  always_ff @(posedge clock_in) begin
    if (sys_rst_in)
      page_reg <= PAGE_RST;
    else if (reg_wr_in && reg_addr_in == REG_PAGE)
      page_reg <= reg_wdata_in;
  end

  // Read data stands one cycle, zero otherwise
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !reg_rd_in)
      reg_rdata_out <= 8'h00;
    else begin
      case (reg_addr_in)
        REG_FLAGS:  reg_rdata_out <= flags_out;
        REG_PAGE:   reg_rdata_out <= page_reg;
        REG_STATUS: reg_rdata_out <= {3'h0, scheme_out, latch_b_out, latch_a_out, halt_out};
        REG_PC_LO:  reg_rdata_out <= pc_reg[7:0];
        REG_PC_HI:  reg_rdata_out <= pc_reg[15:8];
        default:    reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  property p_flip;
    exe && cls == OC_FLIP |=> flags_out[F_C] == !$past(flags_out[F_C]) &&
      flags_out[F_H] == $past(flags_out[F_C]) && !flags_out[F_N] &&
      $stable(flags_out[F_S]) && $stable(flags_out[F_Z]) && $stable(flags_out[F_PV]);
  endproperty
  a_flip: assert property (p_flip) else $error("flip carry wrong");
  property p_one_cycle;
    exe && (cls == OC_FLIP || cls == OC_FORCE || cls == OC_IDLE) && !take
      |=> cyc_out.fetch && t_reg == 2'h0 ##3 last;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("op not one cycle");
  property p_force;
    exe && cls == OC_FORCE |=> flags_out[F_C] && !flags_out[F_H] && !flags_out[F_N] &&
      $stable(flags_out[F_S]) && $stable(flags_out[F_Z]) && $stable(flags_out[F_PV]);
  endproperty
  a_force: assert property (p_force) else $error("force carry wrong");
  // Acceptance at the end of an idle op clears the latches by design
  property p_idle;
    exe && cls == OC_IDLE && !take && !(reg_wr_in && reg_addr_in == REG_FLAGS)
      |=> $stable(flags_out) && $stable(latch_a_out) && $stable(scheme_out);
  endproperty
  a_idle: assert property (p_idle) else $error("idle op changed state");
  property p_halt;
    halt_out && !(last && irq_req_in && latch_a_out) |=> halt_out;
  endproperty
  a_halt: assert property (p_halt) else $error("halt left early");
  property p_halt_runs;
    halt_out |=> t_reg == $past(t_reg) + 2'h1;
  endproperty
  a_halt_runs: assert property (p_halt_runs) else $error("halt stopped sequencing");
  property p_mask;
    exe && cls == OC_MASK |=> !latch_a_out && !latch_b_out && state_reg != ST_ACK;
  endproperty
  a_mask: assert property (p_mask) else $error("mask failed");
  property p_ignore;
    last && !latch_a_out |=> state_reg != ST_ACK;
  endproperty
  a_ignore: assert property (p_ignore) else $error("masked request taken");
  property p_unmask;
    exe && cls == OC_UNMASK |=> latch_a_out && latch_b_out && state_reg != ST_ACK;
  endproperty
  a_unmask: assert property (p_unmask) else $error("unmask wrong");
  property p_jam_read;
    state_reg == ST_EXT && jam_reg |-> cyc_out.mread && !cyc_out.fetch;
  endproperty
  a_jam_read: assert property (p_jam_read) else $error("jammed byte fetched");
  property p_restart;
    last && state_reg == ST_ACK && scheme_out == SCH_RESTART
      |=> branch_out && branch_addr_out == RESTART_ADDR;
  endproperty
  a_restart: assert property (p_restart) else $error("restart target wrong");
  property p_pointer;
    last && state_reg == ST_ACK && scheme_out == SCH_VECTOR
      |=> cyc_out.mread && cyc_out.addr == {page_reg, $past(data_reg)};
  endproperty
  a_pointer: assert property (p_pointer) else $error("pointer wrong");
  property p_entry;
    last && state_reg == ST_TBL_HI |=> branch_out && branch_addr_out == {$past(data_reg), lo_reg};
  endproperty
  a_entry: assert property (p_entry) else $error("table entry wrong");
  c_halt_exit: cover property (halt_out ##1 state_reg == ST_ACK);
  c_vector:    cover property (state_reg == ST_TBL_HI ##1 branch_out);
  c_jam_ext:   cover property (state_reg == ST_EXT && jam_reg);
endmodule : ccg_control

// ===== hw/ccg_pkg.sv
// ==========================================================
// Shared constants and types
// ==========================================================
package ccg_pkg;
  // Opcode bytes
  localparam logic [7:0] OP_IDLE    = 8'h00;
  localparam logic [7:0] OP_FLIP_CY = 8'h3F;
  localparam logic [7:0] OP_FORCE_CY = 8'h37;
  localparam logic [7:0] OP_HALT    = 8'h76;
  localparam logic [7:0] OP_MASK    = 8'hF3;
  localparam logic [7:0] OP_UNMASK  = 8'hFB;
  localparam logic [7:0] OP_EXT     = 8'hED;
  localparam logic [7:0] OP_SCHEME0 = 8'h46;
  localparam logic [7:0] OP_SCHEME1 = 8'h56;
  localparam logic [7:0] OP_SCHEME2 = 8'h5E;
  // Fixed restart target and reset values
  localparam logic [15:0] RESTART_ADDR = 16'h0038;
  localparam logic [15:0] PC_RST       = 16'h0000;
  localparam logic [7:0]  FLAGS_RST    = 8'h00;
  localparam logic [7:0]  PAGE_RST     = 8'h00;
  // Clock states within one machine cycle
  localparam logic [1:0] T_SAMPLE = 2'h2;
  localparam logic [1:0] T_LAST   = 2'h3;
  // Flag bit positions
  localparam int F_S  = 7;
  localparam int F_Z  = 6;
  localparam int F_H  = 4;
  localparam int F_PV = 2;
  localparam int F_N  = 1;
  localparam int F_C  = 0;
  // Register offsets
  localparam logic [3:0] REG_FLAGS  = 4'h0;
  localparam logic [3:0] REG_PAGE   = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_PC_LO  = 4'h3;
  localparam logic [3:0] REG_PC_HI  = 4'h4;
  // Interrupt response schemes
  typedef enum logic [1:0] {SCH_JAM, SCH_RESTART, SCH_VECTOR} ccg_scheme_t;
  // Machine cycle sequencer states
  typedef enum logic [2:0] {ST_FETCH, ST_EXT, ST_HALT, ST_ACK, ST_TBL_LO, ST_TBL_HI} ccg_state_t;
  // Opcode classes
  typedef enum logic [2:0] {OC_IDLE, OC_FLIP, OC_FORCE, OC_HALT, OC_MASK, OC_UNMASK, OC_EXT} ccg_opc_t;
  // Bus cycle descriptor
  typedef struct packed {
    logic        fetch;
    logic        ack;
    logic        mread;
    logic [15:0] addr;
  } ccg_cyc_t;
endpackage : ccg_pkg

// ===== verification/ccg_peripheral.sv
`timescale 1ns/10ps
// ==========================================
// Interrupting peripheral and memory model
module ccg_peripheral
  import ccg_pkg::*;
(
  input  wire logic       clock_in,
  input  wire ccg_cyc_t   cyc_in,
  input  wire logic [7:0] ack_byte_in,
  input  wire logic       slow_in,
  output logic      [7:0] data_out
);
  logic [7:0] mem [0:65535]; // Program, table and jam source
  ccg_cyc_t   cyc_q;         // Previous cycle, spots a new one
  // Empty memory, bus starts at a known pattern
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    data_out = 8'h5A;
  end
  // Answers each cycle; changing garbage on a new cycle's first edge when slow, and when not addressed
  always @(posedge clock_in) begin
    cyc_q <= cyc_in;
    if (slow_in && cyc_in != cyc_q) begin
      data_out <= ~data_out;
    end else if (cyc_in.ack) begin
      data_out <= ack_byte_in;
    end else if (cyc_in.fetch || cyc_in.mread) begin
      data_out <= mem[cyc_in.addr];
    end else begin
      data_out <= ~data_out;
    end
  end
endmodule : ccg_peripheral

// ===== verification/tb_ccg_control.sv
`timescale 1ns/10ps
// ==========================================
// Bench for the control instruction block
module tb_ccg_control
  import ccg_pkg::*;
;
  logic        clock_in, sys_rst_in, irq_req_in, reg_wr_in, reg_rd_in;
  logic [3:0]  reg_addr_in;
  logic [7:0]  reg_wdata_in, reg_rdata_out, flags_out;
  logic [7:0]  ack_byte;        // Byte handed over on acknowledge
  logic        slow;            // Late peripheral data
  logic [7:0]  data_bus;        // Data bus byte
  ccg_cyc_t    cyc_out;
  logic        halt_out, latch_a_out, latch_b_out, branch_out;
  ccg_scheme_t scheme_out;
  logic [15:0] branch_addr_out;
  int          n_fail = 0;      // Mismatches
  int          total_checks = 0;
  int          seed;            // Random seed
  int          edge_n;          // Edges since reset release
  int          n_br;            // Branch pulses since reset
  int          ends;            // Edge of the model's last instruction end
  logic [15:0] last_mread;      // Latest memory read address
  logic [7:0]  mf;              // Model flags
  logic        ma, mb, mh;      // Model latches and halt
  logic [1:0]  msch;            // Model scheme
  logic [15:0] pc;              // Model program counter
  logic [7:0]  fops [3];        // Flag opcode pool

  ccg_control i_ccg_control (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .data_in(data_bus), .irq_req_in(irq_req_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .cyc_out(cyc_out), .reg_rdata_out(reg_rdata_out), .halt_out(halt_out), .latch_a_out(latch_a_out),
    .latch_b_out(latch_b_out), .scheme_out(scheme_out), .branch_out(branch_out),
    .branch_addr_out(branch_addr_out), .flags_out(flags_out));
  ccg_peripheral i_ccg_peripheral (
    .clock_in(clock_in), .cyc_in(cyc_out), .ack_byte_in(ack_byte), .slow_in(slow), .data_out(data_bus));

  // ==========================================
  // Clock and bookkeeping
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // Edges, branch pulses and memory reads
  always @(posedge clock_in) begin
    edge_n <= sys_rst_in ? 0 : edge_n + 1;
    n_br   <= sys_rst_in ? 0 : n_br + int'(branch_out);
    if (cyc_out.mread === 1'b1) begin
      last_mread <= cyc_out.addr;
    end
  end

  // ==========================================
  // Tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Waits until just after edge n
  task automatic wait_edge(input int n);
    while (edge_n < n) begin
      @(posedge clock_in);
      #1;
    end
  endtask : wait_edge
  // Flags, latches, scheme and halt against the model
  task automatic compare_all();
    chk("flags", 16'(flags_out), 16'(mf));
    chk("latch_a", 16'(latch_a_out), 16'(ma));
    chk("latch_b", 16'(latch_b_out), 16'(mb));
    chk("scheme", 16'(scheme_out), 16'(msch));
    chk("halt", 16'(halt_out), 16'(mh));
  endtask : compare_all
  // Register read, data only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("rdata", 16'(reg_rdata_out), 16'(exp));
    @(posedge clock_in);
    #1;
    chk("rdata_idle", 16'(reg_rdata_out), 16'h0000);
  endtask : rd
  // Program at address 0, idle bytes after it
  task automatic put(input logic [79:0] p);
    for (int i = 0; i < 64; i++) begin
      i_ccg_peripheral.mem[i] = (i < 10) ? p[8*(9-i)+:8] : OP_IDLE;
    end
  endtask : put
  // Reset, then flags and page written back to back
  task automatic start(input logic [7:0] fl, input logic [7:0] pg, input logic irq,
                       input logic [7:0] ack, input logic sl);
    irq_req_in <= irq;
    ack_byte   <= ack;
    slow       <= sl;
    sys_rst_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    sys_rst_in   <= 1'b0;
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= REG_FLAGS;
    reg_wdata_in <= fl;
    @(posedge clock_in);
    reg_addr_in  <= REG_PAGE;
    reg_wdata_in <= pg;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
    #1;
    mf = fl;
    {ma, mb, mh, msch} = '0;
    ends = 0;
    pc = 16'h0000;
  endtask : start
  // Model steps n instructions, compared at each end
  task automatic run(input int n);
    logic [7:0] op;
    logic [7:0] b2;
    int         cy;
    for (int k = 0; k < n; k++) begin
      op = i_ccg_peripheral.mem[pc];
      b2 = i_ccg_peripheral.mem[pc + 16'h0001];
      cy = (op == OP_EXT) ? 2 : 1;
      case (op)
        OP_FLIP_CY: begin
          mf[F_H] = mf[F_C];
          mf[F_N] = 1'b0;
          mf[F_C] = ~mf[F_C];
        end
        OP_FORCE_CY: begin
          mf[F_C] = 1'b1;
          mf[F_H] = 1'b0;
          mf[F_N] = 1'b0;
        end
        OP_HALT: mh = 1'b1;
        OP_MASK: {ma, mb} = 2'b00;
        OP_UNMASK: {ma, mb} = 2'b11;
        OP_EXT: begin
          if (b2 == OP_SCHEME0) msch = SCH_JAM;
          if (b2 == OP_SCHEME1) msch = SCH_RESTART;
          if (b2 == OP_SCHEME2) msch = SCH_VECTOR;
        end
        default: ;
      endcase
      pc   = pc + ((op == OP_HALT) ? 16'h0000 : 16'(cy));
      ends = ends + 4 * cy;
      wait_edge(ends);
      compare_all();
    end
  endtask : run
  // Branch awaited; its edge and target compared
  task automatic wait_br(input int lim, input int at, input logic [15:0] addr);
    while (edge_n < lim && branch_out !== 1'b1) begin
      @(posedge clock_in);
      #1;
    end
    chk("branch_edge", 16'(edge_n), 16'(at));
    chk("branch_addr", branch_addr_out, addr);
  endtask : wait_br
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clock_in);
    n_fail++;
    summarize();
  end

  // ==========================================
  // Test sequence
  initial begin
    logic [7:0] v, pg, lo, hi;
    {sys_rst_in, irq_req_in, reg_wr_in, reg_rd_in, slow} = 5'b10000;
    {reg_addr_in, reg_wdata_in, ack_byte} = '0;
    {mf, ma, mb, mh, msch} = '0;
    fops = '{OP_IDLE, OP_FLIP_CY, OP_FORCE_CY};
    seed = 83965;
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    #1;
    compare_all();
    rd(REG_FLAGS, FLAGS_RST);
    rd(REG_PAGE, PAGE_RST);
    rd(REG_STATUS, 8'h00);
    rd(4'hF, 8'h00);
    $display("test reset_values done");
    // Random carry and idle streams from random flags
    repeat (2) begin
      put(80'h0);
      for (int i = 1; i < 40; i++) begin
        i_ccg_peripheral.mem[i] = fops[$unsigned($random(seed)) % 3];
      end
      start(8'($random(seed)), 8'h00, 1'b0, 8'h00, 1'b0);
      run(40);
    end
    $display("test carry_ops done");
    // Scheme select, unmask, two more selects, then mask
    put(80'h00ED_5EFB_ED46_ED56_F300);
    start(8'($random(seed)), 8'h00, 1'b0, 8'h00, 1'b1);
    run(7);
    rd(REG_PC_LO, pc[7:0]);
    rd(REG_STATUS, {3'b000, msch, mb, ma, mh});
    rd(REG_PC_HI, pc[15:8]);
    $display("test schemes done");
    // Request held from the start: refused until after the instruction that follows unmask
    put(80'h00ED_56FB_3F00_0000_0000);
    start(8'h00, 8'h00, 1'b1, 8'h00, 1'b0);
    run(3);
    wait_br(60, 24, RESTART_ADDR);
    $display("test restart done");
    // Masking right after unmask keeps requests out
    put(80'h00ED_56FB_F300_0000_0000);
    start(8'h00, 8'h00, 1'b1, 8'h00, 1'b0);
    run(4);
    wait_edge(100);
    chk("branches", 16'(n_br), 16'h0000);
    $display("test masked done");
    // Vectored call through a random table entry
    pg = 8'($random(seed)) | 8'h80;
    v  = 8'($random(seed)) & 8'hFE;
    lo = 8'($random(seed));
    hi = 8'($random(seed));
    put(80'h00ED_5EFB_0000_0000_0000);
    i_ccg_peripheral.mem[{pg, v}] = lo;
    i_ccg_peripheral.mem[{pg, v} + 16'h0001] = hi;
    start(8'h00, pg, 1'b1, v, 1'b1);
    wait_br(80, 32, {hi, lo});
    $display("test vectored done");
    // Jammed two-byte select; second byte by memory read
    put(80'h00ED_46FB_0056_0000_0000);
    start(8'h00, 8'h00, 1'b1, OP_EXT, 1'b0);
    wait_edge(28);
    chk("jam_scheme", 16'(scheme_out), 16'(SCH_RESTART));
    chk("jam_mread", last_mread, 16'h0005);
    chk("jam_branch", 16'(n_br), 16'h0000);
    $display("test jammed done");
    // Suspended core runs idle cycles until a request
    put(80'h00ED_56FB_0076_0000_0000);
    start(8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
    run(7);
    chk("idle_kind", 16'({cyc_out.fetch, cyc_out.ack, cyc_out.mread}), 16'h0000);
    irq_req_in <= 1'b1;
    wait_br(80, 40, RESTART_ADDR);
    chk("halt_left", 16'(halt_out), 16'h0000);
    $display("test halt done");
    summarize();
  end
endmodule : tb_ccg_control
